// ===== hw/ibrd_top.v
// I2C bit rate divider with AXI4-Lite register access and bus timing engine.
// Function
// - Multiplier code 00,01,10 gives one, two, four.
// - Bit rate is clock over multiplier times divider.
// - Index and multiplier pick divider and hold counts.
// - Data held multiplier times hold after fall.
// - Start: clock falls multiplier times hold later.
// - Stop: data rises multiplier times hold later.
`timescale 1ns/1ps
`include "ibrd_consts.vh"
module ibrd_top (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  // AXI4-Lite write address channel.
  input wire [`IBRD_AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data channel.
  input wire [`IBRD_DW-1:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response channel.
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address channel.
  input wire [`IBRD_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data channel.
  output wire [`IBRD_DW-1:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Bus command port.
  input wire cmd_valid,
  input wire [1:0] cmd_code,
  input wire cmd_bit,
  output wire cmd_ready,
  output wire cmd_done,
  output wire rx_bit,
  // Open-drain serial clock pin.
  input wire scl_i,
  output wire scl_o,
  output wire scl_oe,
  // Open-drain serial data pin.
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe
);

  // Engine states.
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_START = 3'h1;
  localparam [2:0] ST_SHOLD = 3'h2;
  localparam [2:0] ST_LOW = 3'h3;
  localparam [2:0] ST_HIGHW = 3'h4;
  localparam [2:0] ST_HIGH = 3'h5;
  localparam [2:0] ST_PHOLD = 3'h6;

  ////////////////////////////////////////////////////////////////////////////
  // Multiplier decode.

  // Turns the multiplier field into a shift; the reserved code acts as one.
  function [1:0] rate_multiplier_shift;
    input [1:0] code;
    begin
      case (code)
        `IBRD_RATE_MULTIPLIER_X1: rate_multiplier_shift = `IBRD_SHIFT_1;
        `IBRD_RATE_MULTIPLIER_X2: rate_multiplier_shift = `IBRD_SHIFT_2;
        `IBRD_RATE_MULTIPLIER_X4: rate_multiplier_shift = `IBRD_SHIFT_4;
        default: rate_multiplier_shift = `IBRD_SHIFT_1;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and bus slave state.

  reg [7:0] bus_clock_divider_r;
  reg awready_r, wready_r, bvalid_r, arready_r, rvalid_r, aw_have_r, w_have_r, wstrb_q_r;
  reg [1:0] bresp_r, rresp_r;
  reg [`IBRD_DW-1:0] rdata_r;
  reg [`IBRD_AW-1:0] awaddr_q_r;
  reg [7:0] wdata_q_r;

  // Engine state.
  reg [2:0] state_r;
  reg [1:0] op_r;
  reg [`IBRD_CW-1:0] cnt_r;
  reg bit_r, scl_oe_r, sda_oe_r, pin_low_r, cmd_ready_r, done_r, rx_bit_r;

  // Filtered pin levels, table values and the scaled timing counts.
  wire [1:0] pin_lvl;
  wire scl_s, sda_s;
  wire [1:0] shift;
  wire [`IBRD_CW-1:0] tab_div, tab_sda, tab_start, tab_stop, period_c, low_c, high_c;
  wire [`IBRD_CW-1:0] sda_hold_c, start_hold_c, stop_hold_c, cnt_inc;

  ////////////////////////////////////////////////////////////////////////////
  // Submodules.

  // Pins pass the three-stage filter before the engine looks at them.
  ibrd_sync #(
    .W(2)
  ) u_sync (
    .ref_clk(ref_clk),
    .srst(srst),
    .pin_in({sda_i, scl_i}),
    .level_out(pin_lvl)
  );

  // Divider and hold counts for the programmed rate index.
  ibrd_lut u_lut (
    .clock_rate_index(bus_clock_divider_r[`IBRD_ICR_HI:`IBRD_ICR_LO]),
    .scl_div(tab_div),
    .sda_hold(tab_sda),
    .start_hold(tab_start),
    .stop_hold(tab_stop)
  );

  assign scl_s = pin_lvl[0];
  assign sda_s = pin_lvl[1];

  // Every count is scaled by the multiplier factor.
  assign shift = rate_multiplier_shift(bus_clock_divider_r[`IBRD_RATE_MULTIPLIER_HI:`IBRD_RATE_MULTIPLIER_LO]);
  assign period_c = tab_div << shift;
  assign low_c = period_c >> 1;
  assign high_c = period_c - low_c;
  assign sda_hold_c = tab_sda << shift;
  assign start_hold_c = tab_start << shift;
  assign stop_hold_c = tab_stop << shift;
  assign cnt_inc = cnt_r + 16'h0001;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  // Address and data are taken in either order; the response follows both.
  always @(posedge ref_clk) begin
    if (srst) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_q_r <= {`IBRD_AW{1'b0}};
      wdata_q_r <= 8'h00;
      wstrb_q_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `IBRD_RESP_OKAY;
      bus_clock_divider_r <= `IBRD_DIVIDER_RST;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        aw_have_r <= 1'b1;
        awaddr_q_r <= s_axi_awaddr;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        w_have_r <= 1'b1;
        wdata_q_r <= s_axi_wdata[7:0];
        wstrb_q_r <= s_axi_wstrb[0];
        wready_r <= 1'b0;
      end
      if (aw_have_r && w_have_r && !bvalid_r) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid_r <= 1'b1;
        if (awaddr_q_r == `IBRD_OFS_DIVIDER) begin
          bresp_r <= `IBRD_RESP_OKAY;
          if (wstrb_q_r) begin
            bus_clock_divider_r <= wdata_q_r;
          end
        end else if (awaddr_q_r == `IBRD_OFS_STATUS) begin
          bresp_r <= `IBRD_RESP_OKAY;
        end else begin
          bresp_r <= `IBRD_RESP_SLVERR;
        end
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  // One read at a time; the answer comes on the edge after the address.
  always @(posedge ref_clk) begin
    if (srst) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= `IBRD_RESP_OKAY;
      rdata_r <= {`IBRD_DW{1'b0}};
    end else begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        if (s_axi_araddr == `IBRD_OFS_DIVIDER) begin
          rresp_r <= `IBRD_RESP_OKAY;
          rdata_r <= {24'h000000, bus_clock_divider_r};
        end else if (s_axi_araddr == `IBRD_OFS_STATUS) begin
          rresp_r <= `IBRD_RESP_OKAY;
          rdata_r <= {24'h000000, 1'b0, sda_s, scl_s, !cmd_ready_r, rx_bit_r, state_r};
        end else begin
          rresp_r <= `IBRD_RESP_SLVERR;
          rdata_r <= {`IBRD_DW{1'b0}};
        end
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus timing engine.

  // Drives start, data bits and stop with the programmed rate and holds.
  always @(posedge ref_clk) begin
    if (srst) begin
      state_r <= ST_IDLE;
      op_r <= `IBRD_CMD_START;
      bit_r <= 1'b0;
      cnt_r <= {`IBRD_CW{1'b0}};
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      pin_low_r <= 1'b0;
      cmd_ready_r <= 1'b1;
      done_r <= 1'b0;
      rx_bit_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          cnt_r <= {`IBRD_CW{1'b0}};
          if (cmd_valid && cmd_ready_r) begin
            cmd_ready_r <= 1'b0;
            op_r <= cmd_code;
            bit_r <= cmd_bit;
            if (cmd_code == `IBRD_CMD_START) begin
              state_r <= ST_START;
            end else begin
              state_r <= ST_LOW;
            end
          end
        end
        ST_START: begin
          // Wait for a free bus, then pull data low while clock stays high.
          if (scl_s && sda_s) begin
            sda_oe_r <= 1'b1;
            cnt_r <= {`IBRD_CW{1'b0}};
            state_r <= ST_SHOLD;
          end
        end
        ST_SHOLD: begin
          cnt_r <= cnt_inc;
          if (cnt_inc >= start_hold_c) begin
            scl_oe_r <= 1'b1;
            done_r <= 1'b1;
            cmd_ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_LOW: begin
          // Data changes only once the hold after the falling clock is over.
          cnt_r <= cnt_inc;
          if (cnt_inc == sda_hold_c) begin
            sda_oe_r <= (op_r == `IBRD_CMD_STOP) ? 1'b1 : !bit_r;
          end
          if (cnt_inc >= low_c) begin
            scl_oe_r <= 1'b0;
            state_r <= ST_HIGHW;
          end
        end
        ST_HIGHW: begin
          // A stretching slave holds the clock low; the high half waits for it.
          cnt_r <= {`IBRD_CW{1'b0}};
          if (scl_s) begin
            state_r <= (op_r == `IBRD_CMD_STOP) ? ST_PHOLD : ST_HIGH;
          end
        end
        ST_HIGH: begin
          cnt_r <= cnt_inc;
          if (cnt_inc >= high_c) begin
            rx_bit_r <= sda_s;
            scl_oe_r <= 1'b1;
            done_r <= 1'b1;
            cmd_ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        ST_PHOLD: begin
          cnt_r <= cnt_inc;
          if (cnt_inc >= stop_hold_c) begin
            sda_oe_r <= 1'b0;
            done_r <= 1'b1;
            cmd_ready_r <= 1'b1;
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          scl_oe_r <= 1'b0;
          sda_oe_r <= 1'b0;
          cmd_ready_r <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flip-flops.

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign cmd_ready = cmd_ready_r;
  assign cmd_done = done_r;
  assign rx_bit = rx_bit_r;
  // Open drain: the driven level is always low, the enable does the work.
  assign scl_o = pin_low_r;
  assign sda_o = pin_low_r;
  assign scl_oe = scl_oe_r;
  assign sda_oe = sda_oe_r;

endmodule // ibrd_top

// ===== hw/ibrd_consts.vh
// Shared constants of the I2C bit rate divider block.
`ifndef IBRD_CONSTS_VH
`define IBRD_CONSTS_VH

// Register bus geometry.
`define IBRD_AW 4
`define IBRD_DW 32
`define IBRD_RESP_OKAY 2'h0
`define IBRD_RESP_SLVERR 2'h2

// Register byte offsets.
`define IBRD_OFS_DIVIDER 4'h0
`define IBRD_OFS_STATUS 4'h4

// Reset value of the bus clock divider register.
`define IBRD_DIVIDER_RST 8'h00

// Field positions inside the bus clock divider register.
`define IBRD_RATE_MULTIPLIER_HI 7
`define IBRD_RATE_MULTIPLIER_LO 6
`define IBRD_ICR_HI 5
`define IBRD_ICR_LO 0

// Rate multiplier codes.
`define IBRD_RATE_MULTIPLIER_X1 2'h0
`define IBRD_RATE_MULTIPLIER_X2 2'h1
`define IBRD_RATE_MULTIPLIER_X4 2'h2

// Shift amounts that stand for the multiplier factors.
`define IBRD_SHIFT_1 2'h0
`define IBRD_SHIFT_2 2'h1
`define IBRD_SHIFT_4 2'h2

// Width of all timing counts.
`define IBRD_CW 16

// Bus commands taken on the user port.
`define IBRD_CMD_START 2'h0
`define IBRD_CMD_BIT 2'h1
`define IBRD_CMD_STOP 2'h2

// Divider table bases, one for each low index code.
`define IBRD_BASE_0 16'h0014
`define IBRD_BASE_1 16'h0016
`define IBRD_BASE_2 16'h0018
`define IBRD_BASE_3 16'h001a
`define IBRD_BASE_4 16'h001c
`define IBRD_BASE_5 16'h001e
`define IBRD_BASE_6 16'h0022
`define IBRD_BASE_7 16'h0028

// Offsets that derive the hold counts from the divider.
`define IBRD_SDA_HOLD_ADD 16'h0001
`define IBRD_START_HOLD_SUB 16'h0003
`define IBRD_STOP_HOLD_ADD 16'h0001

`endif

// ===== hw/ibrd_sync.v
// Three-stage pin synchroniser with agreement filter.
`timescale 1ns/1ps
module ibrd_sync #(
  parameter W = 2
) (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  // Raw pins and filtered levels.
  input wire [W-1:0] pin_in,
  output wire [W-1:0] level_out
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg s1_r;
      reg s2_r;
      reg s3_r;
      reg lvl_r;
      // A new level counts once stages two and three agree; idle bus reads high.
      always @(posedge ref_clk) begin
        if (srst) begin
          s1_r <= 1'b1;
          s2_r <= 1'b1;
          s3_r <= 1'b1;
          lvl_r <= 1'b1;
        end else begin
          s1_r <= pin_in[g];
          s2_r <= s1_r;
          s3_r <= s2_r;
          if (s2_r == s3_r) begin
            lvl_r <= s3_r;
          end
        end
      end
      assign level_out[g] = lvl_r;
    end
  endgenerate

endmodule // ibrd_sync

// ===== hw/ibrd_lut.v
// Constant table of serial clock divider and hold counts per rate index.
`timescale 1ns/1ps
`include "ibrd_consts.vh"
module ibrd_lut (
  // Rate index.
  input wire [5:0] clock_rate_index,
  // Table outputs in module clock periods before the multiplier.
  output wire [`IBRD_CW-1:0] scl_div,
  output wire [`IBRD_CW-1:0] sda_hold,
  output wire [`IBRD_CW-1:0] start_hold,
  output wire [`IBRD_CW-1:0] stop_hold
);

  // Base divider picked by the three low index bits.
  function [`IBRD_CW-1:0] base_of;
    input [2:0] code;
    begin
      case (code)
        3'h0: base_of = `IBRD_BASE_0;
        3'h1: base_of = `IBRD_BASE_1;
        3'h2: base_of = `IBRD_BASE_2;
        3'h3: base_of = `IBRD_BASE_3;
        3'h4: base_of = `IBRD_BASE_4;
        3'h5: base_of = `IBRD_BASE_5;
        3'h6: base_of = `IBRD_BASE_6;
        default: base_of = `IBRD_BASE_7;
      endcase
    end
  endfunction

  // High index bits double the divider per step; holds track it.
  assign scl_div = base_of(clock_rate_index[2:0]) << clock_rate_index[5:3];
  assign sda_hold = (scl_div >> 3) + `IBRD_SDA_HOLD_ADD;
  assign start_hold = (scl_div >> 1) - `IBRD_START_HOLD_SUB;
  assign stop_hold = (scl_div >> 1) + `IBRD_STOP_HOLD_ADD;

endmodule // ibrd_lut

// ===== verif/ibrd_bus_dev.sv
// Model of the devices on the two-wire bus: pull-ups, clock stretching and a data pull.
`timescale 1ns/1ps
module ibrd_bus_dev (
  // Clock.
  input wire ref_clk,
  // Line pulls of the block under test.
  input wire scl_oe,
  input wire sda_oe,
  // Behaviour controls from the bench.
  input wire [3:0] stretch,
  input wire sda_pull,
  // Line levels seen by the block.
  output wire scl_i,
  output wire sda_i
);
  reg [3:0] hold_r = 4'h0;
  reg scl_oe_r = 1'b0;
  wire release_now;

  // A release of the clock by the block starts a stretch of the given length.
  assign release_now = scl_oe_r && !scl_oe && (stretch != 4'h0);
  always @(posedge ref_clk) begin
    scl_oe_r <= scl_oe;
    if (release_now) begin
      hold_r <= stretch - 4'h1;
    end else if (hold_r != 4'h0) begin
      hold_r <= hold_r - 4'h1;
    end
  end

  // Both lines are wired-AND with pull-ups, so a released line reads high.
  assign scl_i = !(scl_oe || release_now || (hold_r != 4'h0));
  assign sda_i = !(sda_oe || sda_pull);
endmodule // ibrd_bus_dev

// ===== verif/ibrd_top_sva.sv
// Checker of register bus answers and serial line timing of the bit rate divider.
`timescale 1ns/1ps
`include "ibrd_consts.vh"
module ibrd_top_sva (
  // Clock and reset.
  input wire ref_clk,
  input wire srst,
  // Register bus.
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`IBRD_AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [`IBRD_DW-1:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Command port and line pulls.
  input wire cmd_valid,
  input wire cmd_ready,
  input wire cmd_done,
  input wire scl_oe,
  input wire sda_oe
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (srst);

  // Start and stop edges: data moves while the clock line is released.
  sequence s_start_edge;
    !scl_oe && $rose(sda_oe);
  endsequence
  sequence s_stop_edge;
    !scl_oe && $fell(sda_oe);
  endsequence

  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("Write response missing.");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write response dropped.");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("Read answer late.");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read data dropped.");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr[3] |=>
    s_axi_rresp == `IBRD_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("Bad unmapped read.");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("Upper read bits set.");
  a_cmd_take: assert property (cmd_valid && cmd_ready |=> !cmd_ready)
    else $error("Command port stayed ready.");
  a_done_pulse: assert property (cmd_done |-> cmd_ready ##1 !cmd_done)
    else $error("Done pulse malformed.");
  a_start_hold: assert property (s_start_edge |=> !scl_oe [*6])
    else $error("Clock fell too soon after start.");
  a_sda_hold: assert property ($rose(scl_oe) |=> $stable(sda_oe) [*2])
    else $error("Data moved too soon after clock fall.");
  a_scl_high: assert property ($fell(scl_oe) |-> !scl_oe [*8])
    else $error("Clock high phase too short.");
  a_stop_hold: assert property (s_stop_edge |-> $past(scl_oe, 8) == 1'b0)
    else $error("Data rose too soon after clock rise.");
endmodule // ibrd_top_sva

// ===== verif/tb_top.sv
// Self-checking bench of the I2C bit rate divider.
`timescale 1ns/1ps
`include "ibrd_consts.vh"
module tb_top;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0, stretch = 4'h0;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  reg s_axi_rready = 1'b0, cmd_valid = 1'b0, cmd_bit = 1'b0, sda_pull = 1'b0;
  reg [31:0] s_axi_wdata = 32'h0, rd;
  reg [1:0] cmd_code = 2'h0, rsp;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire cmd_ready, cmd_done, rx_bit, scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe;
  integer err_total = 0, checks_done = 0, cyc = 0, t_sf = 0, t_sr = 0, t_df = 0, t_dr = 0;
  integer per = 0, k, s, mul, dv, hc, sdh, sth, sph;
  reg scl_q = 1'b0, sda_q = 1'b0;
  integer bases [8] = '{20, 22, 24, 26, 28, 30, 34, 40};
  reg [1:0] mults [4] = '{2'h0, 2'h1, 2'h2, 2'h3};
  reg [5:0] icrs [4] = '{6'h00, 6'h07, 6'h0b, 6'h14};
  reg [3:0] strs [4] = '{4'h0, 4'h0, 4'h3, 4'h2};

  ibrd_top i_ibrd_top (.ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .cmd_valid, .cmd_code, .cmd_bit, .cmd_ready, .cmd_done,
    .rx_bit, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe);
  ibrd_bus_dev i_ibrd_bus_dev (.ref_clk, .scl_oe, .sda_oe, .stretch, .sda_pull, .scl_i, .sda_i);

  // Clock of 25 ns period.
  always #12.5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Cycle stamps of every line pull change, and the run ceiling.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    scl_q <= scl_oe;
    sda_q <= sda_oe;
    if (scl_oe && !scl_q) begin
      t_sf <= cyc;
      per <= cyc - t_sf;
    end
    if (!scl_oe && scl_q) t_sr <= cyc;
    if (sda_oe && !sda_q) t_df <= cyc;
    if (!sda_oe && sda_q) t_dr <= cyc;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      final_report;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compares a seen value with the expected one and counts the outcome.
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks_done = checks_done + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One register write; the response code lands in rsp.
  task axi_wr(input [3:0] a, input [31:0] d, input [3:0] st);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    do @(posedge ref_clk); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  // One register read; data and response land in rd and rsp.
  task axi_rd(input [3:0] a);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One bus command; returns two cycles after its done pulse so the stamps have settled.
  task cmd(input [1:0] c, input b);
    @(posedge ref_clk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_bit <= b;
    do @(posedge ref_clk); while (!cmd_ready);
    cmd_valid <= 1'b0;
    do @(posedge ref_clk); while (!cmd_done);
    repeat (2) @(posedge ref_clk);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Register access, then a full transfer at each multiplier code.
  initial begin
    repeat (5) @(posedge ref_clk);
    srst <= 1'b0;
    axi_rd(`IBRD_OFS_DIVIDER);
    chk("divider_reset", rd, {24'h0, `IBRD_DIVIDER_RST});
    // Idle status: both filtered lines high, engine idle and not busy.
    axi_rd(`IBRD_OFS_STATUS);
    chk("status_idle", rd, 32'h0000_0060);
    chk("pin_level_low", {scl_o, sda_o}, 2'h0);
    axi_wr(`IBRD_OFS_DIVIDER, 32'h0000_00a5, 4'hf);
    axi_wr(`IBRD_OFS_DIVIDER, 32'h0000_003c, 4'h0);
    axi_wr(`IBRD_OFS_STATUS, 32'h0000_00ff, 4'hf);
    chk("status_write_resp", rsp, `IBRD_RESP_OKAY);
    axi_rd(`IBRD_OFS_DIVIDER);
    chk("divider_readback", rd, 32'h0000_00a5);
    axi_wr(4'h8, 32'h0000_0011, 4'hf);
    chk("unmapped_write_resp", rsp, `IBRD_RESP_SLVERR);
    axi_rd(4'hc);
    chk("unmapped_read_resp", rsp, `IBRD_RESP_SLVERR);
    $display("test registers done");
    for (k = 0; k < 4; k = k + 1) begin
      mul = (mults[k] == `IBRD_RATE_MULTIPLIER_X4) ? 4 : (mults[k] == `IBRD_RATE_MULTIPLIER_X2) ? 2 : 1;
      dv = bases[icrs[k][2:0]] << icrs[k][5:3];
      hc = dv * mul - (dv * mul) / 2;
      sdh = (dv / 8 + 1) * mul;
      sth = (dv / 2 - 3) * mul;
      sph = (dv / 2 + 1) * mul;
      axi_wr(`IBRD_OFS_DIVIDER, {24'h0, mults[k], icrs[k]}, 4'h1);
      stretch <= strs[k];
      cmd(`IBRD_CMD_START, 1'b0);
      chk("start_hold", t_sf - t_df, sth);
      cmd(`IBRD_CMD_BIT, 1'b1);
      chk("rx_released", rx_bit, 1'b1);
      s = t_sf;
      cmd(`IBRD_CMD_BIT, 1'b0);
      chk("sda_hold", (t_df - s >= sdh) && (t_df - s <= sdh + 5), 1);
      // The bench leaves five idle cycles between commands; the pin filter adds a few more.
      s = per - dv * mul - strs[k];
      chk("bit_period", (s >= 5) && (s <= 13), 1);
      s = t_sf - t_sr - strs[k] - hc;
      chk("scl_high", (s >= 0) && (s <= 6), 1);
      sda_pull <= 1'b1;
      cmd(`IBRD_CMD_BIT, 1'b1);
      sda_pull <= 1'b0;
      chk("rx_pulled", rx_bit, 1'b0);
      cmd(`IBRD_CMD_STOP, 1'b0);
      s = t_dr - t_sr - strs[k];
      chk("stop_hold", (s >= sph) && (s <= sph + 6), 1);
      $display("test timing %0d done", k);
    end
    final_report;
  end
endmodule // tb_top

bind ibrd_top ibrd_top_sva i_ibrd_top_sva (.ref_clk, .srst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .cmd_valid, .cmd_ready, .cmd_done, .scl_oe, .sda_oe);
